// >>> rtl/remote_link_pkg.sv
// shared constants and types for the remote sensor link control block
// assumes apb byte addressing with each register on one aligned word
package remote_link_pkg;

   // register indexes; the byte address is four times the index
   localparam logic [13:0] IDX_REMOTE_COMMAND = 14'h00fc;
   localparam logic [13:0] IDX_FLYBACK_CTRL = 14'h210c;
   localparam logic [13:0] IDX_SENSOR_ENABLES = 14'h2709;
   localparam logic [13:0] IDX_RESP_HIGH = 14'h2602;
   localparam logic [13:0] IDX_RESP_LOW = 14'h2603;

   // field layout
   localparam int CMD_W = 5;
   localparam int CMD_TARGET_LSB = 3;
   localparam int FLYBACK_BIT = 3;
   localparam int EN_LSB = 3;
   localparam int SENSOR_NUM = 3;
   localparam int RESP_W = 16;

   // values after reset
   localparam logic [4:0] CMD_RESET = 5'h00;
   localparam logic FLYBACK_RESET = 1'b0;
   localparam logic [2:0] EN_RESET = 3'h0;
   localparam logic [15:0] RESP_RESET = 16'h0000;

   // target code with no sensor behind it
   localparam logic [1:0] TARGET_NONE = 2'h3;

   // system clock cycles per link bit and per power pulse phase
   localparam int LINK_TICK_CYCLES = 16;

   // register decode results
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_CMD,
      SEL_FLY,
      SEL_EN,
      SEL_RESP_HI,
      SEL_RESP_LO
   } reg_sel_t;

   // serial command engine states
   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_SEND,
      LINK_RECV
   } link_state_t;

endpackage

// >>> rtl/power_pulse_driver.sv
// power pulse driver for one remote sensor
// assumes a one-cycle phase tick from the shared divider
`timescale 1ns/1ps
module power_pulse_driver
   import remote_link_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_flyback_disable,
   input wire logic i_tick,
   output logic o_pulse,
   output logic o_pulse_oe
);

   logic phase_high_reg;
   logic pulse_reg;
   logic pulse_oe_reg;

   // phase toggles per tick; restarts high when enabled again
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_high_reg <= 1'b1;
      end else if (!i_enable) begin
         phase_high_reg <= 1'b1;
      end else if (i_tick) begin
         phase_high_reg <= ~phase_high_reg;
      end
   end

   // high phase driven; low phase released or driven low
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pulse_reg <= 1'b0;
         pulse_oe_reg <= 1'b0;
      end else begin
         pulse_reg <= i_enable & phase_high_reg;
         // fly-back leaves the pin open so the coil can swing
         pulse_oe_reg <= i_enable &
            (phase_high_reg | i_flyback_disable);
      end
   end

   assign o_pulse = pulse_reg;
   assign o_pulse_oe = pulse_oe_reg;

   AST_FLY_RELEASE: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_enable && !i_flyback_disable && !phase_high_reg) |=>
         (!o_pulse_oe && !o_pulse))
      else $error("low phase not released in fly-back mode");

   AST_HIGH_DRIVEN: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_enable && phase_high_reg) |=> (o_pulse && o_pulse_oe))
      else $error("high phase not driven");

   AST_ACTIVE_LOW: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (i_enable && i_flyback_disable) ##1 (i_enable && i_flyback_disable)
         |-> o_pulse_oe ##1 o_pulse_oe)
      else $error("pulse released while fly-back disabled");

   COV_FLYBACK: cover property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      o_pulse && o_pulse_oe ##1 !o_pulse_oe);

endmodule

// >>> rtl/link_shifter.sv
// serial command engine on the shared remote data line
// assumes the sensor answers on the same line after the command bits
`timescale 1ns/1ps
module link_shifter
   import remote_link_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_tick,
   input wire logic i_start,
   input wire logic [CMD_W-1:0] i_cmd,
   input wire logic i_data,
   output logic o_data,
   output logic o_data_oe,
   output logic o_busy,
   output logic o_done,
   output logic [RESP_W-1:0] o_resp
);

   link_state_t state_reg;
   logic [CMD_W-1:0] shift_reg;
   logic [4:0] bit_cnt_reg;
   logic data_reg;
   logic data_oe_reg;
   logic done_reg;
   logic [RESP_W-1:0] resp_reg;

   // command bits out msb first, then sixteen response bits in
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= LINK_IDLE;
         shift_reg <= CMD_RESET;
         bit_cnt_reg <= 5'h00;
         data_reg <= 1'b0;
         data_oe_reg <= 1'b0;
         resp_reg <= RESP_RESET;
      end else begin
         case (state_reg)
            LINK_IDLE: begin
               if (i_start) begin
                  state_reg <= LINK_SEND;
                  shift_reg <= i_cmd;
                  bit_cnt_reg <= 5'h00;
                  data_reg <= i_cmd[CMD_W-1];
                  data_oe_reg <= 1'b1;
               end
            end
            LINK_SEND: begin
               if (i_tick) begin
                  if (bit_cnt_reg == 5'(CMD_W - 1)) begin
                     state_reg <= LINK_RECV;
                     bit_cnt_reg <= 5'h00;
                     data_oe_reg <= 1'b0; // hand the line to the sensor
                     data_reg <= 1'b0;
                  end else begin
                     shift_reg <= {shift_reg[CMD_W-2:0], 1'b0};
                     data_reg <= shift_reg[CMD_W-2];
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  end
               end
            end
            LINK_RECV: begin
               if (i_tick) begin
                  resp_reg <= {resp_reg[RESP_W-2:0], i_data};
                  if (bit_cnt_reg == 5'(RESP_W - 1)) begin
                     state_reg <= LINK_IDLE;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  end
               end
            end
            default: begin
               state_reg <= LINK_IDLE;
            end
         endcase
      end
   end

   // completion pulse on the last response bit
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (state_reg == LINK_RECV) && i_tick &&
            (bit_cnt_reg == 5'(RESP_W - 1));
      end
   end

   assign o_data = data_reg;
   assign o_data_oe = data_oe_reg;
   assign o_busy = (state_reg != LINK_IDLE);
   assign o_done = done_reg;
   assign o_resp = resp_reg;

   AST_SEND_DRIVES: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (state_reg == LINK_SEND) |-> o_data_oe)
      else $error("command bit not driven");

   AST_RECV_RELEASED: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (state_reg == LINK_RECV) |-> !o_data_oe)
      else $error("line driven during response");

   COV_EXCHANGE: cover property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (state_reg == LINK_RECV) ##1 o_done);

endmodule

// >>> rtl/remote_sensor_link_control.sv
// remote sensor link control: apb registers, command launch, pulses
// assumes an apb master on i_sys_clk and an external wire resolver
//
// Behaviour
// - non-zero command write starts remote command if its target sensor is enabled
// - command field returns to zero when done
// - fly-back mode: pulse high, then open
// - fly-back disabled: pulse driven high and low
// - three sensor enables, bits 3-5, reset off
// - 16-bit read response in two bytes
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module remote_sensor_link_control
   import remote_link_pkg::*;
#(
   parameter int TICK_CYCLES = LINK_TICK_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [15:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [SENSOR_NUM-1:0] o_power_pulse,
   output logic [SENSOR_NUM-1:0] o_power_pulse_oe,
   output logic o_link_data,
   output logic o_link_data_oe,
   input wire logic i_link_data
);

   localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   // register decode, shared by read mux and error answer
   function automatic reg_sel_t decode(input logic [15:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr[1:0] != 2'h0) begin
         sel = SEL_NONE;
      end else if (addr[15:2] == IDX_REMOTE_COMMAND) begin
         sel = SEL_CMD;
      end else if (addr[15:2] == IDX_FLYBACK_CTRL) begin
         sel = SEL_FLY;
      end else if (addr[15:2] == IDX_SENSOR_ENABLES) begin
         sel = SEL_EN;
      end else if (addr[15:2] == IDX_RESP_HIGH) begin
         sel = SEL_RESP_HI;
      end else if (addr[15:2] == IDX_RESP_LOW) begin
         sel = SEL_RESP_LO;
      end
      return sel;
   endfunction

   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [CMD_W-1:0] cmd_reg;
   logic flyback_disable_reg;
   logic [SENSOR_NUM-1:0] enables_reg;
   logic [RESP_W-1:0] resp_reg;
   logic launched_reg;
   logic [TICK_W-1:0] tick_cnt_reg;
   logic tick_reg;
   logic [31:0] read_next;
   logic access;
   logic commit_wr;
   logic pending;
   logic target_ok;
   logic start;
   logic link_busy;
   logic link_done;
   logic [RESP_W-1:0] link_resp;
   logic [1:0] target;
   reg_sel_t sel;

   assign sel = decode(i_paddr);
   assign access = i_psel & i_penable;
   // a write takes effect on the edge that samples pready high
   assign commit_wr = access & pready_reg & i_pwrite & i_pstrb[0];

   // one wait state: pready rises the cycle after the access phase starts
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= access & ~pready_reg;
      end
   end

   // read data and error flag captured as pready rises
   always_comb begin
      read_next = 32'h0000_0000;
      if (sel == SEL_CMD) begin
         read_next[CMD_W-1:0] = cmd_reg;
      end else if (sel == SEL_FLY) begin
         read_next[FLYBACK_BIT] = flyback_disable_reg;
      end else if (sel == SEL_EN) begin
         read_next[EN_LSB +: SENSOR_NUM] = enables_reg;
      end else if (sel == SEL_RESP_HI) begin
         read_next[7:0] = resp_reg[15:8];
      end else if (sel == SEL_RESP_LO) begin
         read_next[7:0] = resp_reg[7:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (access & ~pready_reg) begin
         prdata_reg <= i_pwrite ? 32'h0000_0000 : read_next;
         pslverr_reg <= (sel == SEL_NONE);
      end else begin
         pslverr_reg <= 1'b0;
      end
   end

   // launch decision for a freshly written command
   assign pending = (cmd_reg != CMD_RESET) & ~launched_reg;
   assign target = cmd_reg[CMD_TARGET_LSB +: 2];
   assign target_ok = (target != TARGET_NONE) && enables_reg[target];
   assign start = pending & target_ok;

   // command field: software sets, hardware clears on completion;
   // writes during a command are dropped so a run is never corrupted
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_reg <= CMD_RESET;
      end else if (link_done) begin
         cmd_reg <= CMD_RESET;
      end else if (pending & ~target_ok) begin
         cmd_reg <= CMD_RESET; // no enabled sensor: finish at once
      end else if (commit_wr && sel == SEL_CMD && cmd_reg == CMD_RESET) begin
         cmd_reg <= i_pwdata[CMD_W-1:0];
      end
   end

   // marks that the current command already went to the engine
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         launched_reg <= 1'b0;
      end else if (link_done) begin
         launched_reg <= 1'b0;
      end else if (start) begin
         launched_reg <= 1'b1;
      end
   end

   // pulse mode control
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flyback_disable_reg <= FLYBACK_RESET;
      end else if (commit_wr && sel == SEL_FLY) begin
         flyback_disable_reg <= i_pwdata[FLYBACK_BIT];
      end
   end

   // per sensor interface enables
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enables_reg <= EN_RESET;
      end else if (commit_wr && sel == SEL_EN) begin
         enables_reg <= i_pwdata[EN_LSB +: SENSOR_NUM];
      end
   end

   // response is read-only; only the engine updates it
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         resp_reg <= RESP_RESET;
      end else if (link_done) begin
         resp_reg <= link_resp;
      end
   end

   // bit and phase tick divider, one-cycle enable
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
         tick_reg <= 1'b0;
      end
   end

   // one power pulse driver per sensor, gated by that sensor's enable
   genvar g;
   generate
      for (g = 0; g < SENSOR_NUM; g++) begin : gen_pulse
         power_pulse_driver u_pulse (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(i_rst_n),
            .i_enable(enables_reg[g]),
            .i_flyback_disable(flyback_disable_reg),
            .i_tick(tick_reg),
            .o_pulse(o_power_pulse[g]),
            .o_pulse_oe(o_power_pulse_oe[g])
         );
      end
   endgenerate

   link_shifter u_link (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_tick(tick_reg),
      .i_start(start),
      .i_cmd(cmd_reg),
      .i_data(i_link_data),
      .o_data(o_link_data),
      .o_data_oe(o_link_data_oe),
      .o_busy(link_busy),
      .o_done(link_done),
      .o_resp(link_resp)
   );

   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;

   AST_CMD_LAUNCH: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      start |=> link_busy && launched_reg)
      else $error("command accepted but engine not started");

   AST_CMD_STORED: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (commit_wr && sel == SEL_CMD && cmd_reg == CMD_RESET && !link_done)
         |=> cmd_reg == $past(i_pwdata[CMD_W-1:0]))
      else $error("command write not stored");

   AST_CMD_CLEARED: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      link_done |=> (cmd_reg == CMD_RESET) && !launched_reg)
      else $error("command field not cleared on completion");

   AST_CMD_HELD: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (launched_reg && !link_done) |=> cmd_reg == $past(cmd_reg))
      else $error("command field changed during a command");

   AST_EN_WRITE: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (commit_wr && sel == SEL_EN) |=>
         enables_reg == $past(i_pwdata[EN_LSB +: SENSOR_NUM]))
      else $error("enable write not stored");

   AST_RESP_CAPTURE: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      link_done |=> resp_reg == $past(link_resp))
      else $error("response not captured");

   AST_RESP_STABLE: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      !link_done |=> $stable(resp_reg))
      else $error("response changed without a completion");

   AST_PREADY_ONE: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      o_pready |=> !o_pready)
      else $error("pready held past one cycle");

   AST_FLY_WRITE: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (commit_wr && sel == SEL_FLY) |=>
         flyback_disable_reg == $past(i_pwdata[FLYBACK_BIT]))
      else $error("pulse mode write not stored");

   AST_BAD_TARGET: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (pending && !target_ok) |=> (cmd_reg == CMD_RESET) && !link_busy)
      else $error("command without a sensor not cleared");

   AST_SLVERR_MAP: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (access && !pready_reg) |=>
         o_pready && (o_pslverr == $past(sel == SEL_NONE)))
      else $error("error answer does not match the decode");

   AST_RESP_HI_READ: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (access && !pready_reg && !i_pwrite && sel == SEL_RESP_HI)
         |=> o_prdata == {24'h00_0000, $past(resp_reg[15:8])})
      else $error("response upper byte read wrong");

   AST_RESP_LO_READ: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (access && !pready_reg && !i_pwrite && sel == SEL_RESP_LO)
         |=> o_prdata == {24'h00_0000, $past(resp_reg[7:0])})
      else $error("response lower byte read wrong");

   COV_CMD_DONE: cover property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      start ##[1:1000] link_done);

   COV_UNMAPPED: cover property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      o_pready && o_pslverr);

endmodule

// >>> test/remote_sensor_model.sv
// behavioural isolated sensor on the shared serial data line
// assumes TICK matches the design's tick period, at least 4 cycles
`timescale 1ns/1ps
module remote_sensor_model #(
   parameter int TICK = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_line_oe,
   input wire logic i_line,
   output logic o_line,
   output logic [4:0] o_cmd_seen
);
   logic [63:0] hist;
   logic oe_d;
   logic tx;
   logic [4:0] c;
   logic [15:0] resp;
   int cnt;
   int m;

   // command bits read mid-bit from the history; the first may be short
   assign c = {hist[4*TICK], hist[3*TICK+TICK/2], hist[2*TICK+TICK/2],
      hist[TICK+TICK/2], hist[TICK/2]};
   // response bit index for the current count
   assign m = (cnt - (TICK/2 - 2)) / TICK;

   // history decode at line turnaround
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hist <= '0;
         oe_d <= 1'b0;
         tx <= 1'b0;
         o_line <= 1'b0;
         o_cmd_seen <= 5'h00;
         resp <= 16'h0000;
         cnt <= 0;
      end else begin
         oe_d <= i_line_oe;
         if (i_line_oe) begin
            hist <= {hist[62:0], i_line};
         end
         if (oe_d && !i_line_oe) begin
            o_cmd_seen <= c;
            resp <= {3'b101, c, ~c, 3'b011};
            o_line <= 1'b1;
            cnt <= 0;
            tx <= 1'b1;
         end else if (tx) begin
            cnt <= cnt + 1;
            // change mid-way between sampling ticks for margin
            if (cnt >= TICK && (cnt - (TICK/2 - 2)) % TICK == 0) begin
               if (m < 16) begin
                  o_line <= resp[15-m];
               end else begin
                  o_line <= ~o_line; // inverted after the last bit: no stale level
                  tx <= 1'b0;
               end
            end
         end
      end
   end
endmodule

// >>> test/remote_sensor_link_control_tb.sv
// self-checking bench: apb register access, commands, power pulses
// the bench itself resolves the shared line: the design when it drives, else the sensor model
`timescale 1ns/1ps
module remote_sensor_link_control_tb
   import remote_link_pkg::*;
;
   localparam int T = 4;
   localparam logic [15:0] A_CMD = {IDX_REMOTE_COMMAND, 2'b00};
   localparam logic [15:0] A_FLY = {IDX_FLYBACK_CTRL, 2'b00};
   localparam logic [15:0] A_EN = {IDX_SENSOR_ENABLES, 2'b00};
   localparam logic [15:0] A_RHI = {IDX_RESP_HIGH, 2'b00};
   localparam logic [15:0] A_RLO = {IDX_RESP_LOW, 2'b00};
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [3:0] pstrb;
   logic [2:0] pulse, pulse_oe;
   logic ld, ld_oe, model_line, line, err;
   logic [4:0] cmd_seen, c;
   logic [4:0] cmds [3] = '{5'h05, 5'h0b, 5'h16};
   logic [15:0] regs [5] = '{A_CMD, A_FLY, A_EN, A_RHI, A_RLO};
   int errors, checked, cycles, flt, lowd, hi, oth;

   assign line = ld_oe ? ld : model_line;

   remote_sensor_link_control #(.TICK_CYCLES(T))
      remote_sensor_link_control_inst (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_power_pulse(pulse),
      .o_power_pulse_oe(pulse_oe), .o_link_data(ld),
      .o_link_data_oe(ld_oe), .i_link_data(line));

   remote_sensor_model #(.TICK(T)) remote_sensor_model_inst (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_line_oe(ld_oe),
      .i_line(line), .o_line(model_line), .o_cmd_seen(cmd_seen));

   always #2 clk = ~clk;

   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [15:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // polls the command field; the wait is bounded
   task automatic wait_clear();
      int n;
      n = 0;
      v = 32'h0000_001f;
      while (v[4:0] !== 5'h00 && n < 200) begin
         apb(1'b0, A_CMD, 32'h0000_0000);
         v = rd;
         n++;
      end
   endtask

   // counts float, driven-low and high cycles of sensor s
   task automatic watch(input int s);
      flt = 0;
      lowd = 0;
      hi = 0;
      oth = 0;
      // skip the edge whose outputs still follow the old enables
      @(posedge clk);
      repeat (4*T) begin
         @(posedge clk);
         if (pulse_oe[s] !== 1'b1) flt++;
         else if (pulse[s] === 1'b0) lowd++;
         else hi++;
         if ((pulse_oe & ~(3'h1 << s)) !== 3'h0) oth++;
      end
   endtask

   initial begin
      clk = 0;
      rst_n = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h1;
      errors = 0;
      checked = 0;
      cycles = 0;
      repeat (10) @(posedge clk);
      check({26'h0, pulse_oe, pulse}, 32'h0000_0000);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, regs[i], 32'h0000_0000);
         check(rd, 32'h0000_0000);
      end
      apb(1'b1, A_EN, 32'hffff_ffff);
      apb(1'b0, A_EN, 32'h0000_0000);
      check(rd, 32'h0000_0038);
      apb(1'b1, A_FLY, 32'hffff_ffff);
      apb(1'b0, A_FLY, 32'h0000_0000);
      check(rd, 32'h0000_0008);
      // a write with byte lane 0 off leaves the field alone
      pstrb <= 4'h0;
      apb(1'b1, A_FLY, 32'h0000_0000);
      pstrb <= 4'h1;
      apb(1'b0, A_FLY, 32'h0000_0000);
      check(rd, 32'h0000_0008);
      apb(1'b0, 16'h0100, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      apb(1'b1, A_CMD + 16'h0002, 32'h0000_0005);
      check({31'h0, err}, 32'h0000_0001);
      apb(1'b1, A_RLO, 32'h0000_00ff);
      apb(1'b0, A_RLO, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      // each sensor alone, in both pulse modes
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, A_FLY, 32'(f) << 3);
         for (int s = 0; s < 3; s++) begin
            apb(1'b1, A_EN, 32'h0000_0008 << s);
            watch(s);
            check(32'(hi > 0), 32'h0000_0001);
            check(32'(flt > 0), 32'(f == 0));
            check(32'(lowd > 0), 32'(f == 1));
            check(32'(oth), 32'h0000_0000);
         end
      end
      // one command per sensor; a write while busy is dropped
      apb(1'b1, A_EN, 32'h0000_0038);
      for (int t = 0; t < 3; t++) begin
         c = cmds[t];
         apb(1'b1, A_CMD, {27'h0, c});
         apb(1'b1, A_CMD, {27'h0, ~c});
         apb(1'b0, A_CMD, 32'h0000_0000);
         check(rd, {27'h0, c});
         wait_clear();
         check(v, 32'h0000_0000);
         check({27'h0, cmd_seen}, {27'h0, c});
         apb(1'b0, A_RHI, 32'h0000_0000);
         check(rd, {24'h0, 3'b101, c});
         apb(1'b0, A_RLO, 32'h0000_0000);
         check(rd, {24'h0, ~c, 3'b011});
      end
      // no sensor behind target 3, then a disabled target
      apb(1'b1, A_CMD, 32'h0000_001a);
      wait_clear();
      check(v, 32'h0000_0000);
      apb(1'b1, A_EN, 32'h0000_0000);
      apb(1'b1, A_CMD, 32'h0000_0001);
      wait_clear();
      check(v, 32'h0000_0000);
      check({27'h0, cmd_seen}, 32'h0000_0016);
      // mid-run reset: enables and response go back to zero
      apb(1'b1, A_EN, 32'h0000_0038);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, A_EN, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b0, A_RHI, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      print_verdict();
   end
endmodule
